// File: hw/its_pkg.sv
package its_pkg;

   localparam int          ADDR_W        = 7;
   localparam int          BYTE_W        = 8;
   localparam int          NREG_DEF      = 256;
   localparam logic [7:0]  PTR_RESET     = 8'h00;
   localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
   localparam logic [1:0]  LVL_LOW       = 2'h0;
   localparam logic [1:0]  LVL_RES       = 2'h1;
   localparam logic [1:0]  LVL_FLT       = 2'h2;
   localparam logic [1:0]  LVL_HIGH      = 2'h3;
   localparam logic [1:0]  MODE_PINS     = LVL_LOW;
   localparam logic [6:0]  ADDR_BASE_LOW = 7'h44;
   localparam logic [6:0]  ADDR_BASE_RES = 7'h20;
   localparam logic [6:0]  ADDR_BASE_FLT = 7'h10;
   localparam logic [6:0]  ADDR_BASE_HI  = 7'h0C;
   localparam logic [1:0]  STRAP_SETTLE  = 2'h2;
   localparam int          CORE_PERIOD_NS = 20;
   localparam int          SCL_PERIOD_NS  = 160;
   localparam int          SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CORE_PERIOD_NS);

   typedef enum logic [1:0] {CMD_WRITE, CMD_READ_CUR, CMD_READ_RS} its_cmd_t;

   // pad sense: [1] pin above mid level, [0] pin follows the weak test pull
   function automatic logic [1:0] its_lvl_decode(input logic [1:0] sense);
      its_lvl_decode = {sense[1], sense[1] ^ sense[0]};
   endfunction

   function automatic logic [6:0] its_tgt_addr(input logic [1:0] a1, input logic [1:0] a0);
      logic [6:0] base;
      unique case (a1)
         LVL_LOW: base = ADDR_BASE_LOW;
         LVL_RES: base = ADDR_BASE_RES;
         LVL_FLT: base = ADDR_BASE_FLT;
         LVL_HIGH: base = ADDR_BASE_HI;
      endcase
      its_tgt_addr = base | {5'h00, a0};
   endfunction

endpackage

// File: hw/its_if.sv
interface its_if;
   logic scl_ctl_oe;
   logic scl_ctl_o;
   logic sda_ctl_oe;
   logic sda_ctl_o;
   logic sda_tgt_oe;
   logic sda_tgt_o;
   logic scl;
   logic sda;

   // open-drain wires with pull-ups
   assign scl = scl_ctl_oe ? scl_ctl_o : 1'b1;
   assign sda = (sda_ctl_oe ? sda_ctl_o : 1'b1) & (sda_tgt_oe ? sda_tgt_o : 1'b1);

   modport target (input scl, input sda, output sda_tgt_oe, output sda_tgt_o);
   modport controller (input sda, output scl_ctl_oe, output scl_ctl_o,
                       output sda_ctl_oe, output sda_ctl_o);
endinterface

// File: hw/its_target.sv
// What this block does
// - write starts with address, direction zero, acked
// - one offset byte follows, msb first, acked
// - any number of data bytes, each acked
// - controller ends every write with stop
// - offset-only write loads the read pointer
// - plain read starts at 00h or last+1
// - read after write starts at written offset
// - repeated start resends address with read bit
// - read data shifts out msb first
// - controller acks every byte but last
// - sample controller ack, send next byte
// - on nack release data, await stop
// - controller ends every read with stop
// - pointer advances after every read byte
// - reads after power-up walk from zero
// - controller touches documented offsets only
// - serial access only when mode strap nonzero
// - address from two straps, float-float 0x12
// - four-level strap decodes to two bits
// - scl input pin, open-drain sda pin
module its_target #(
   parameter int NREG = its_pkg::NREG_DEF
) (
   input  wire logic       i_core_clk,
   input  wire logic       i_rstn,
   its_if.target           bus,
   input  wire logic [1:0] i_mode_strap_sense,
   input  wire logic [1:0] i_address_strap_high_sense,
   input  wire logic [1:0] i_address_strap_low_sense,
   input  wire logic [7:0] i_peek_offset,
   output logic            o_i2c_mode,
   output logic [6:0]      o_tgt_addr,
   output logic            o_wr_stb,
   output logic [7:0]      o_wr_offset,
   output logic [7:0]      o_wr_data,
   output logic [7:0]      o_peek_data
);

   typedef enum {T_IDLE, T_ADDR, T_ACK_ADDR, T_OFFSET, T_ACK_OFF,
                 T_WDATA, T_ACK_DATA, T_RDATA, T_RACK, T_WAIT_STOP} its_tstate_t;

   its_tstate_t state_ff;
   logic [2:0]  scl_sync_ff;
   logic [2:0]  sda_sync_ff;
   logic [5:0]  strap_s1_ff;
   logic [5:0]  strap_s2_ff;
   logic [1:0]  settle_ff;
   logic        mode_ff;
   logic [6:0]  addr_ff;
   logic [3:0]  cnt_ff;
   logic [7:0]  rx_ff;
   logic [7:0]  tx_ff;
   logic [7:0]  ptr_ff;
   logic        rw_ff;
   logic        acked_ff;
   logic        sda_oe_ff;
   logic        sda_o_ff;
   logic        wr_stb_ff;
   logic [7:0]  wr_off_ff;
   logic [7:0]  wr_data_ff;
   logic [7:0]  peek_ff;
   logic [7:0]  mem_ff [NREG];

   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic sda_in;
   logic [7:0] rd_byte;

   function automatic logic [7:0] reg_read(input logic [7:0] idx);
      reg_read = (int'(idx) < NREG) ? mem_ff[idx] : 8'h00;
   endfunction

   // only the second and third stages feed logic; the first one settles
   assign sda_in     = sda_sync_ff[1];
   assign scl_rise   = scl_sync_ff[1] & ~scl_sync_ff[2];
   assign scl_fall   = ~scl_sync_ff[1] & scl_sync_ff[2];
   assign start_cond = scl_sync_ff[1] & scl_sync_ff[2] & sda_sync_ff[2] & ~sda_sync_ff[1];
   assign stop_cond  = scl_sync_ff[1] & scl_sync_ff[2] & ~sda_sync_ff[2] & sda_sync_ff[1];
   assign rd_byte    = reg_read(ptr_ff);

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         scl_sync_ff <= 3'h7;
         sda_sync_ff <= 3'h7;
      end else begin
         scl_sync_ff <= {scl_sync_ff[1:0], bus.scl};
         sda_sync_ff <= {sda_sync_ff[1:0], bus.sda};
      end
   end

   // straps are caught once, after reset release and the synchroniser
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         strap_s1_ff <= 6'h00;
         strap_s2_ff <= 6'h00;
         settle_ff   <= 2'h0;
         mode_ff     <= 1'b0;
         addr_ff     <= 7'h00;
      end else begin
         strap_s1_ff <= {i_mode_strap_sense, i_address_strap_high_sense,
                         i_address_strap_low_sense};
         strap_s2_ff <= strap_s1_ff;
         if (settle_ff != its_pkg::STRAP_SETTLE) begin
            settle_ff <= settle_ff + 2'h1;
         end else if (settle_ff == its_pkg::STRAP_SETTLE && !mode_ff && addr_ff == 7'h00) begin
            mode_ff <= its_pkg::its_lvl_decode(strap_s2_ff[5:4]) != its_pkg::MODE_PINS;
            addr_ff <= its_pkg::its_tgt_addr(its_pkg::its_lvl_decode(strap_s2_ff[3:2]),
                                             its_pkg::its_lvl_decode(strap_s2_ff[1:0]));
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_ff   <= T_IDLE;
         cnt_ff     <= 4'h0;
         rx_ff      <= 8'h00;
         tx_ff      <= 8'h00;
         ptr_ff     <= its_pkg::PTR_RESET;
         rw_ff      <= 1'b0;
         acked_ff   <= 1'b0;
         sda_oe_ff  <= 1'b0;
         wr_stb_ff  <= 1'b0;
         wr_off_ff  <= 8'h00;
         wr_data_ff <= 8'h00;
      end else begin
         wr_stb_ff <= 1'b0;
         if (start_cond) begin
            // start or repeated start restarts address reception when mode_ff is set, else goes to T_IDLE
            state_ff  <= mode_ff ? T_ADDR : T_IDLE;
            cnt_ff    <= 4'h0;
            sda_oe_ff <= 1'b0;
         end else if (stop_cond) begin
            state_ff  <= T_IDLE;
            sda_oe_ff <= 1'b0;
         end else begin
            unique case (state_ff)
               T_IDLE, T_WAIT_STOP: begin
               end
               T_ADDR, T_OFFSET, T_WDATA: begin
                  if (scl_rise && cnt_ff != its_pkg::BITS_PER_BYTE) begin
                     rx_ff  <= {rx_ff[6:0], sda_in};
                     cnt_ff <= cnt_ff + 4'h1;
                  end else if (scl_fall && cnt_ff == its_pkg::BITS_PER_BYTE) begin
                     cnt_ff <= 4'h0;
                     if (state_ff == T_ADDR) begin
                        if (rx_ff[7:1] == addr_ff) begin
                           sda_oe_ff <= 1'b1;
                           rw_ff     <= rx_ff[0];
                           state_ff  <= T_ACK_ADDR;
                        end else begin
                           state_ff <= T_IDLE;
                        end
                     end else if (state_ff == T_OFFSET) begin
                        ptr_ff    <= rx_ff;
                        sda_oe_ff <= 1'b1;
                        state_ff  <= T_ACK_OFF;
                     end else begin
                        wr_stb_ff  <= 1'b1;
                        wr_off_ff  <= ptr_ff;
                        wr_data_ff <= rx_ff;
                        ptr_ff     <= ptr_ff + 8'h01;
                        sda_oe_ff  <= 1'b1;
                        state_ff   <= T_ACK_DATA;
                     end
                  end
               end
               T_ACK_ADDR: begin
                  if (scl_fall) begin
                     if (rw_ff) begin
                        sda_oe_ff <= ~rd_byte[7];
                        tx_ff     <= {rd_byte[6:0], 1'b0};
                        cnt_ff    <= 4'h1;
                        state_ff  <= T_RDATA;
                     end else begin
                        sda_oe_ff <= 1'b0;
                        state_ff  <= T_OFFSET;
                     end
                  end
               end
               T_ACK_OFF, T_ACK_DATA: begin
                  if (scl_fall) begin
                     sda_oe_ff <= 1'b0;
                     state_ff  <= T_WDATA;
                  end
               end
               T_RDATA: begin
                  if (scl_fall) begin
                     if (cnt_ff == its_pkg::BITS_PER_BYTE) begin
                        sda_oe_ff <= 1'b0;
                        ptr_ff    <= ptr_ff + 8'h01;
                        state_ff  <= T_RACK;
                     end else begin
                        sda_oe_ff <= ~tx_ff[7];
                        tx_ff     <= {tx_ff[6:0], 1'b0};
                        cnt_ff    <= cnt_ff + 4'h1;
                     end
                  end
               end
               T_RACK: begin
                  if (scl_rise) begin
                     acked_ff <= ~sda_in;
                  end else if (scl_fall) begin
                     if (acked_ff) begin
                        sda_oe_ff <= ~rd_byte[7];
                        tx_ff     <= {rd_byte[6:0], 1'b0};
                        cnt_ff    <= 4'h1;
                        state_ff  <= T_RDATA;
                     end else begin
                        sda_oe_ff <= 1'b0;
                        state_ff  <= T_WAIT_STOP;
                     end
                  end
               end
            endcase
         end
      end
   end

   // storage has no reset; undefined offsets are the controller's problem
   always_ff @(posedge i_core_clk) begin
      if (wr_stb_ff && int'(wr_off_ff) < NREG) begin
         mem_ff[wr_off_ff] <= wr_data_ff;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         peek_ff  <= 8'h00;
         sda_o_ff <= 1'b0;
      end else begin
         peek_ff  <= reg_read(i_peek_offset);
         sda_o_ff <= 1'b0;
      end
   end

   assign bus.sda_tgt_oe = sda_oe_ff;
   assign bus.sda_tgt_o  = sda_o_ff;
   assign o_i2c_mode     = mode_ff;
   assign o_tgt_addr     = addr_ff;
   assign o_wr_stb       = wr_stb_ff;
   assign o_wr_offset    = wr_off_ff;
   assign o_wr_data      = wr_data_ff;
   assign o_peek_data    = peek_ff;

endmodule

// File: hw/its_controller.sv
module its_controller #(
   parameter int QUARTER = its_pkg::SCL_QUARTER_CYC
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_rstn,
   its_if.controller             bus,
   input  wire logic             i_cmd_valid,
   input  wire its_pkg::its_cmd_t i_cmd_kind,
   input  wire logic [6:0]       i_cmd_addr,
   input  wire logic [7:0]       i_cmd_offset,
   input  wire logic [7:0]       i_cmd_len,
   input  wire logic [7:0]       i_wr_data,
   output logic                  o_busy,
   output logic                  o_done,
   output logic                  o_nack,
   output logic                  o_wr_take,
   output logic                  o_rd_valid,
   output logic [7:0]            o_rd_data
);

   typedef enum {H_IDLE, H_START, H_BIT, H_STOP} its_hstate_t;
   typedef enum {S_ADDR_W, S_OFF, S_DATA, S_ADDR_R, S_RECV} its_step_t;

   its_hstate_t       state_ff;
   its_step_t         step_ff;
   its_pkg::its_cmd_t kind_ff;
   logic [15:0] qcnt_ff;
   logic [1:0]  q_ff;
   logic [3:0]  bit_ff;
   logic [7:0]  tx_ff;
   logic [8:0]  rx_ff;
   logic [7:0]  left_ff;
   logic [6:0]  addr_ff;
   logic [7:0]  off_ff;
   logic [1:0]  sda_sync_ff;
   logic        scl_oe_ff;
   logic        sda_oe_ff;
   logic        busy_ff;
   logic        done_ff;
   logic        nack_ff;
   logic        take_ff;
   logic        rdv_ff;
   logic [7:0]  rdd_ff;
   logic        tick;

   assign tick = (qcnt_ff == 16'(QUARTER - 1));

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sda_sync_ff <= 2'h3;
         qcnt_ff     <= 16'h0000;
      end else begin
         sda_sync_ff <= {sda_sync_ff[0], bus.sda};
         qcnt_ff     <= (state_ff == H_IDLE || tick) ? 16'h0000 : qcnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_ff  <= H_IDLE;
         step_ff   <= S_ADDR_W;
         kind_ff   <= its_pkg::CMD_WRITE;
         q_ff      <= 2'h0;
         bit_ff    <= 4'h0;
         tx_ff     <= 8'h00;
         rx_ff     <= 9'h000;
         left_ff   <= 8'h00;
         addr_ff   <= 7'h00;
         off_ff    <= 8'h00;
         scl_oe_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
         busy_ff   <= 1'b0;
         done_ff   <= 1'b0;
         nack_ff   <= 1'b0;
         take_ff   <= 1'b0;
         rdv_ff    <= 1'b0;
         rdd_ff    <= 8'h00;
      end else begin
         done_ff <= 1'b0;
         take_ff <= 1'b0;
         rdv_ff  <= 1'b0;
         unique case (state_ff)
            H_IDLE: begin
               if (i_cmd_valid) begin
                  kind_ff  <= i_cmd_kind;
                  addr_ff  <= i_cmd_addr;
                  off_ff   <= i_cmd_offset;
                  // a read asks for at least one byte
                  left_ff  <= (i_cmd_kind != its_pkg::CMD_WRITE && i_cmd_len == 8'h00) ?
                              8'h01 : i_cmd_len;
                  step_ff  <= (i_cmd_kind == its_pkg::CMD_READ_CUR) ? S_ADDR_R : S_ADDR_W;
                  nack_ff  <= 1'b0;
                  busy_ff  <= 1'b1;
                  q_ff     <= 2'h0;
                  state_ff <= H_START;
               end
            end
            H_START: if (tick) begin
               q_ff <= q_ff + 2'h1;
               unique case (q_ff)
                  2'h0: sda_oe_ff <= 1'b0;
                  2'h1: scl_oe_ff <= 1'b0;
                  2'h2: sda_oe_ff <= 1'b1;
                  2'h3: begin
                     scl_oe_ff <= 1'b1;
                     bit_ff    <= 4'h0;
                     tx_ff     <= {addr_ff, step_ff == S_ADDR_R};
                     state_ff  <= H_BIT;
                  end
               endcase
            end
            H_BIT: if (tick) begin
               q_ff <= q_ff + 2'h1;
               unique case (q_ff)
                  2'h0: begin
                     if (bit_ff != its_pkg::BITS_PER_BYTE) begin
                        sda_oe_ff <= (step_ff != S_RECV) && !tx_ff[7];
                     end else begin
                        sda_oe_ff <= (step_ff == S_RECV) && (left_ff != 8'h01);
                     end
                  end
                  2'h1: scl_oe_ff <= 1'b0;
                  2'h2: rx_ff <= {rx_ff[7:0], sda_sync_ff[1]};
                  2'h3: begin
                     scl_oe_ff <= 1'b1;
                     if (bit_ff != its_pkg::BITS_PER_BYTE) begin
                        tx_ff  <= {tx_ff[6:0], 1'b0};
                        bit_ff <= bit_ff + 4'h1;
                     end else begin
                        bit_ff <= 4'h0;
                        if (step_ff != S_RECV && rx_ff[0]) begin
                           nack_ff  <= 1'b1;
                           state_ff <= H_STOP;
                        end else begin
                           unique case (step_ff)
                              S_ADDR_W: begin
                                 step_ff <= S_OFF;
                                 tx_ff   <= off_ff;
                              end
                              S_OFF: begin
                                 if (kind_ff == its_pkg::CMD_READ_RS) begin
                                    step_ff  <= S_ADDR_R;
                                    state_ff <= H_START;
                                 end else if (left_ff == 8'h00) begin
                                    state_ff <= H_STOP;
                                 end else begin
                                    step_ff <= S_DATA;
                                    tx_ff   <= i_wr_data;
                                    take_ff <= 1'b1;
                                 end
                              end
                              S_DATA: begin
                                 left_ff <= left_ff - 8'h01;
                                 if (left_ff == 8'h01) begin
                                    state_ff <= H_STOP;
                                 end else begin
                                    tx_ff   <= i_wr_data;
                                    take_ff <= 1'b1;
                                 end
                              end
                              S_ADDR_R: step_ff <= S_RECV;
                              S_RECV: begin
                                 rdv_ff  <= 1'b1;
                                 rdd_ff  <= rx_ff[8:1];
                                 left_ff <= left_ff - 8'h01;
                                 if (left_ff == 8'h01) begin
                                    state_ff <= H_STOP;
                                 end
                              end
                           endcase
                        end
                     end
                  end
               endcase
            end
            H_STOP: if (tick) begin
               q_ff <= q_ff + 2'h1;
               unique case (q_ff)
                  2'h0: sda_oe_ff <= 1'b1;
                  2'h1: scl_oe_ff <= 1'b0;
                  2'h2: sda_oe_ff <= 1'b0;
                  2'h3: begin
                     busy_ff  <= 1'b0;
                     done_ff  <= 1'b1;
                     state_ff <= H_IDLE;
                  end
               endcase
            end
         endcase
      end
   end

   // pins only ever pull low; released means pulled up
   assign bus.scl_ctl_oe = scl_oe_ff;
   assign bus.scl_ctl_o  = 1'b0;
   assign bus.sda_ctl_oe = sda_oe_ff;
   assign bus.sda_ctl_o  = 1'b0;
   assign o_busy         = busy_ff;
   assign o_done         = done_ff;
   assign o_nack         = nack_ff;
   assign o_wr_take      = take_ff;
   assign o_rd_valid     = rdv_ff;
   assign o_rd_data      = rdd_ff;

endmodule

// File: sim/its_monitor.sv
module its_monitor #(
   parameter logic [6:0] TGT_ADDR = 7'h12
) (
   input  wire logic i_core_clk,
   input  wire logic i_rstn,
   input  wire logic scl_ctl_oe,
   input  wire logic scl_ctl_o,
   input  wire logic sda_ctl_oe,
   input  wire logic sda_ctl_o,
   input  wire logic sda_tgt_oe,
   input  wire logic sda_tgt_o,
   input  wire logic scl,
   input  wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       scl_q;
   logic       sda_q;
   logic       first;
   logic       rd;
   logic       act;
   logic       nacked;
   logic [3:0] cnt;
   logic [7:0] sh;
   wire        rise = scl && !scl_q;
   wire        bit9 = rise && cnt == 4'h8;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   // start and stop both restart byte framing; only a start opens an address byte
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt <= 4'h0;
         sh <= 8'h00;
         first <= 1'b0;
         rd <= 1'b0;
         act <= 1'b0;
         nacked <= 1'b0;
      end else if (scl && scl_q && sda_q != sda) begin
         cnt <= 4'h0;
         first <= !sda;
         rd <= 1'b0;
         act <= 1'b0;
         nacked <= 1'b0;
      end else if (rise) begin
         sh <= {sh[6:0], sda};
         cnt <= bit9 ? 4'h0 : cnt + 4'h1;
         if (bit9 && first) begin
            first <= 1'b0;
            rd <= sh[0];
            act <= sh[7:1] == TGT_ADDR;
         end
         if (bit9 && rd && act && sda) begin
            nacked <= 1'b1;
         end
      end
   end

   property p_open_drain; !scl_ctl_o && !sda_ctl_o && !sda_tgt_o; endproperty
   property p_scl_low; $fell(scl) |-> !scl [*4]; endproperty
   property p_scl_high; $rose(scl) |-> scl [*4]; endproperty
   property p_tgt_stable; scl && scl_q |-> $stable(sda_tgt_oe); endproperty
   property p_addr_ack; bit9 && first && sh[7:1] == TGT_ADDR |-> !sda; endproperty
   property p_addr_refuse; bit9 && first && sh[7:1] != TGT_ADDR |-> !sda_tgt_oe; endproperty
   property p_wr_ack; bit9 && !first && act && !rd |-> !sda; endproperty
   property p_rd_quiet; rise && !bit9 && act && rd && !nacked |-> !sda_ctl_oe; endproperty
   property p_rd_release; bit9 && !first && act && rd |-> !sda_tgt_oe; endproperty
   property p_nack_silent; nacked |-> !sda_tgt_oe; endproperty

   a_open_drain: assert property (p_open_drain) else $error("line driven high");
   a_scl_low: assert property (p_scl_low) else $error("clock low too short");
   a_scl_high: assert property (p_scl_high) else $error("clock high too short");
   a_tgt_stable: assert property (p_tgt_stable) else $error("data moved, clock high");
   a_addr_ack: assert property (p_addr_ack) else $error("address not acked");
   a_addr_refuse: assert property (p_addr_refuse) else $error("foreign address acked");
   a_wr_ack: assert property (p_wr_ack) else $error("write byte not acked");
   a_rd_quiet: assert property (p_rd_quiet) else $error("controller drove read bit");
   a_rd_release: assert property (p_rd_release) else $error("target held ack bit");
   a_nack_silent: assert property (p_nack_silent) else $error("data after nack");

   c_refuse: cover property (bit9 && first && sh[7:1] != TGT_ADDR);
   c_wr_ack: cover property (bit9 && !first && act && !rd);
   c_rd_nack: cover property (bit9 && act && rd && sda);
endmodule

// File: sim/testbench.sv
`define CHK(a, e) begin \
   tests_run++; \
   if ((a) !== (e)) begin \
      fail_count++; \
      $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); \
   end \
end

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic              i_core_clk;
   logic              i_rstn;
   logic              cmd_valid;
   its_pkg::its_cmd_t cmd_kind;
   logic [6:0]        cmd_addr;
   logic [7:0]        cmd_offset;
   logic [7:0]        cmd_len;
   logic [7:0]        wr_data;
   logic [7:0]        peek_off;
   logic [1:0]        mode_s, a1_s, a0_s;
   logic              busy, done, nack, wr_take, rd_valid, i2c_mode, wr_stb;
   logic [7:0]        rd_data, wr_off, wr_dat, peek_data;
   logic [6:0]        tgt_addr;
   logic [7:0]        mem [256];
   logic [7:0]        wbuf [256];
   logic [7:0]        rq [$];
   int                widx, ptr, exp_woff, cyc, fail_count, tests_run, o, n, wn;

   its_if bus_if();
   its_target u_its_target (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .bus(bus_if),
      .i_mode_strap_sense(mode_s), .i_address_strap_high_sense(a1_s),
      .i_address_strap_low_sense(a0_s), .i_peek_offset(peek_off), .o_i2c_mode(i2c_mode),
      .o_tgt_addr(tgt_addr), .o_wr_stb(wr_stb), .o_wr_offset(wr_off), .o_wr_data(wr_dat),
      .o_peek_data(peek_data));
   its_controller u_its_controller (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .bus(bus_if),
      .i_cmd_valid(cmd_valid), .i_cmd_kind(cmd_kind), .i_cmd_addr(cmd_addr),
      .i_cmd_offset(cmd_offset), .i_cmd_len(cmd_len), .i_wr_data(wr_data), .o_busy(busy),
      .o_done(done), .o_nack(nack), .o_wr_take(wr_take), .o_rd_valid(rd_valid),
      .o_rd_data(rd_data));
   its_monitor u_its_monitor (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
      .scl_ctl_oe(bus_if.scl_ctl_oe), .scl_ctl_o(bus_if.scl_ctl_o),
      .sda_ctl_oe(bus_if.sda_ctl_oe), .sda_ctl_o(bus_if.sda_ctl_o),
      .sda_tgt_oe(bus_if.sda_tgt_oe), .sda_tgt_o(bus_if.sda_tgt_o),
      .scl(bus_if.scl), .sda(bus_if.sda));

   function automatic logic [7:0] exp_rd(int p, int i);
      return mem[(p + i) % 256];
   endfunction

   task automatic close_out();
      if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // only the ptr model decides where an offset-less read begins
   task automatic run(its_pkg::its_cmd_t k, logic [6:0] a, logic [7:0] off, logic [7:0] len);
      int         p;
      int         m;
      logic [7:0] g;
      p = (k == its_pkg::CMD_READ_RS) ? int'(off) : ptr;
      m = (len == 8'h00) ? 1 : int'(len);
      exp_woff = off;
      wn = 0;
      @(posedge i_core_clk);
      cmd_valid <= 1'b1;
      cmd_kind <= k;
      cmd_addr <= a;
      cmd_offset <= off;
      cmd_len <= len;
      @(posedge i_core_clk);
      cmd_valid <= 1'b0;
      while (done !== 1'b1) @(posedge i_core_clk);
      `CHK(busy, 1'b0)
      `CHK(nack, 1'(a != 7'h12))
      if (a != 7'h12) return;
      if (k == its_pkg::CMD_WRITE) begin
         for (int i = 0; i < len; i++) mem[(off + i) % 256] = wbuf[i];
         ptr = (off + len) % 256;
      end else begin
         for (int i = 0; i < m; i++) begin
            g = rq.pop_front();
            `CHK(g, exp_rd(p, i))
         end
         ptr = (p + m) % 256;
      end
   endtask

   initial begin
      i_core_clk = 1'b0;
      forever #10 i_core_clk = ~i_core_clk;
   end

   always @(posedge i_core_clk) begin
      cyc++;
      if (wr_stb === 1'b1) begin
         `CHK(wr_off, 8'(exp_woff))
         `CHK(wr_dat, wbuf[wn % 256])
         exp_woff++;
         wn++;
      end
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      if (cmd_valid) widx = 0;
      else if (wr_take === 1'b1) widx++;
      wr_data <= wbuf[widx % 256];
      // generous ceiling: the fill alone is some 19k cycles
      if (cyc > 60000) begin
         fail_count++;
         close_out();
      end
   end

   initial begin
      i_rstn = 1'b0;
      cmd_valid = 1'b0;
      cmd_kind = its_pkg::CMD_WRITE;
      cmd_addr = 7'h00;
      cmd_offset = 8'h00;
      cmd_len = 8'h00;
      wr_data = 8'h00;
      peek_off = 8'h00;
      {mode_s, a1_s, a0_s} = 6'h1F;
      void'($urandom(19794));
      foreach (wbuf[i]) wbuf[i] = 8'($urandom);
      repeat (3) @(posedge i_core_clk);
      i_rstn <= 1'b1;
      repeat (12) @(posedge i_core_clk);
      `CHK(tgt_addr, 7'h12)
      `CHK(i2c_mode, 1'b1)
      run(its_pkg::CMD_WRITE, 7'h12, 8'h00, 8'hFF);
      run(its_pkg::CMD_WRITE, 7'h12, 8'hFF, 8'h01);
      peek_off <= 8'h10;
      repeat (3) @(posedge i_core_clk);
      `CHK(peek_data, mem[16])
      // two resets: pin mode at another address, then back; registers keep
      for (int r = 0; r < 2; r++) begin
         i_rstn <= 1'b0;
         {mode_s, a1_s, a0_s} <= r ? 6'h1F : 6'h01;
         repeat (3) @(posedge i_core_clk);
         i_rstn <= 1'b1;
         repeat (12) @(posedge i_core_clk);
         `CHK(tgt_addr, r ? 7'h12 : 7'h45)
         `CHK(i2c_mode, 1'(r))
         if (r == 0) run(its_pkg::CMD_WRITE, 7'h45, 8'h40, 8'h01);
      end
      ptr = 0;
      run(its_pkg::CMD_READ_CUR, 7'h12, 8'h00, 8'h03);
      run(its_pkg::CMD_READ_CUR, 7'h12, 8'h00, 8'h02);
      run(its_pkg::CMD_WRITE, 7'h13, 8'h40, 8'h01);
      run(its_pkg::CMD_READ_CUR, 7'h12, 8'h00, 8'h01);
      run(its_pkg::CMD_WRITE, 7'h12, 8'hFE, 8'h00);
      run(its_pkg::CMD_READ_CUR, 7'h12, 8'h00, 8'h03);
      run(its_pkg::CMD_READ_RS, 7'h12, 8'hFF, 8'h02);
      repeat (8) begin
         o = $urandom % 256;
         n = 1 + $urandom % 4;
         foreach (wbuf[i]) wbuf[i] = 8'($urandom);
         run(its_pkg::CMD_WRITE, 7'h12, 8'(o), 8'(n));
         run(its_pkg::CMD_READ_RS, 7'h12, 8'(o), 8'(n));
         run(its_pkg::CMD_READ_CUR, 7'h12, 8'h00, 8'h01);
      end
      close_out();
   end
endmodule
